// ---- uer_pkg.sv ----
// Constants and carrier types for the uncorrectable-error register bank
package uer_pkg;

  // Register byte offsets
  localparam logic [11:0] UER_OFS_NEXT_CAP = 12'h100;
  localparam logic [11:0] UER_OFS_FLAGS = 12'h104;
  localparam logic [11:0] UER_OFS_MASKS = 12'h108;

  // Next-capability pointer field and its two reset values
  localparam int UER_PTR_LSB = 20;
  localparam logic [11:0] UER_PTR_UPSTREAM = 12'h140;
  localparam logic [11:0] UER_PTR_DOWNSTREAM = 12'h20C;

  // Status and mask bit positions
  localparam int UER_BIT_TRAINING = 0;
  localparam int UER_BIT_DL_PROTO = 4;
  localparam int UER_BIT_POISONED = 12;
  localparam int UER_BIT_FC_PROTO = 13;
  localparam int UER_BIT_CPL_TIMEOUT = 14;
  localparam int UER_BIT_CPL_ABORT = 15;
  localparam int UER_BIT_UNEXP_CPL = 16;
  localparam int UER_BIT_RX_OVERFLOW = 17;
  localparam int UER_BIT_MALFORMED = 18;
  localparam int UER_BIT_ECRC = 19;
  localparam int UER_BIT_UNSUP_REQ = 20;

  // Implemented bits; everything else reads zero and ignores writes
  localparam logic [31:0] UER_IMPL_BITS = 32'h001F_F011;
  localparam logic [31:0] UER_FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] UER_MASKS_RESET = 32'h0000_0000;
  localparam logic [31:0] UER_UNMAPPED_DATA = 32'h0000_0000;

  // Error events, one-cycle pulses from the port
  typedef struct packed {
    logic training;
    logic dl_proto;
    logic poisoned;
    logic fc_proto;
    logic cpl_timeout;
    logic cpl_abort;
    logic unexp_cpl;
    logic rx_overflow;
    logic malformed;
    logic ecrc;
    logic unsup_req;
  } uer_evt_s;

  // Whole state of the register bank
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] flags;
    logic [31:0] masks;
    logic [11:0] ptr;
    logic strap_done;
    logic [31:0] report;
  } uer_state_s;

endpackage : uer_pkg

// ---- uer_regs.sv ----
// Uncorrectable-error pointer, status and mask registers on a Wishbone slave
//
// Summary of operation
// RULE_01: Upstream port: read-only 12-bit pointer in bits 31:20, resets to 140h.
// RULE_02: Downstream port: same pointer field resets to 20Ch instead.
// RULE_03: Training error sets status bit 0; write one clears; survives non-power reset.
// RULE_04: Data link protocol error sets sticky status bit 4; write one clears.
// RULE_05: Poisoned packet received or generated sets sticky status bit 12.
// RULE_06: Flow control protocol error sets sticky status bit 13.
// RULE_07: Completion timeout sets sticky status bit 14.
// RULE_08: Completer abort sets sticky status bit 15.
// RULE_09: Unexpected completion sets sticky status bit 16.
// RULE_10: Receive buffer overflow sets sticky status bit 17.
// RULE_11: Malformed packet sets sticky status bit 18.
// RULE_12: End-to-end CRC error sets sticky status bit 19.
// RULE_13: Unsupported request sets sticky status bit 20.
// RULE_14: Mask bits 0 and 4 block logging and reporting of their errors; the code blocks only reporting, status bits 0 and 4 still set.
// RULE_15: Mask bits 12 and 13 block poisoned and flow control reports.
// RULE_16: Mask bits 14 and 15 block completion timeout and abort reports.
// RULE_17: Mask bits 16 and 17 block unexpected completion and overflow reports.
// RULE_18: Mask bits 18 and 19 block malformed and CRC error reports.
// RULE_19: Mask bit 20 blocks unsupported request logging and reporting; the code blocks only reporting, status bit 20 still sets.
// RULE_20: Reserved status and mask bits read zero and ignore writes.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps

module uer_regs (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic link_rst,
  // Port role strap, high for a downstream port
  input wire logic port_downstream,
  // Error events from the port
  input wire uer_pkg::uer_evt_s err_evt,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Unmasked errors to header log and root complex message logic
  output logic [31:0] fault_report
);
  import uer_pkg::*;

  uer_state_s st_ff;
  uer_state_s nxt_st;
  logic [31:0] evt_vec;
  logic [31:0] sel_mask;
  logic req;
  logic commit_wr;
  logic [11:0] word_adr;

  // Events placed at their status bit positions
  always_comb begin
    evt_vec = 32'h0000_0000;
    evt_vec[UER_BIT_TRAINING] = err_evt.training; // [RULE_03]
    evt_vec[UER_BIT_DL_PROTO] = err_evt.dl_proto; // [RULE_04]
    evt_vec[UER_BIT_POISONED] = err_evt.poisoned; // [RULE_05]
    evt_vec[UER_BIT_FC_PROTO] = err_evt.fc_proto; // [RULE_06]
    evt_vec[UER_BIT_CPL_TIMEOUT] = err_evt.cpl_timeout; // [RULE_07]
    evt_vec[UER_BIT_CPL_ABORT] = err_evt.cpl_abort; // [RULE_08]
    evt_vec[UER_BIT_UNEXP_CPL] = err_evt.unexp_cpl; // [RULE_09]
    evt_vec[UER_BIT_RX_OVERFLOW] = err_evt.rx_overflow; // [RULE_10]
    evt_vec[UER_BIT_MALFORMED] = err_evt.malformed; // [RULE_11]
    evt_vec[UER_BIT_ECRC] = err_evt.ecrc; // [RULE_12]
    evt_vec[UER_BIT_UNSUP_REQ] = err_evt.unsup_req; // [RULE_13]
  end

  // Byte enables widened to bit lanes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign sel_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // A request is taken once; the write commits on the edge the master sees ack
  assign req = wb_cyc_i & wb_stb_i;
  assign commit_wr = req & wb_we_i & st_ff.ack;
  assign word_adr = {wb_adr_i[11:2], 2'b00};

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    // Read data latched when the request is first seen
    if (req & ~st_ff.ack) begin
      case (word_adr)
        UER_OFS_NEXT_CAP: nxt_st.rdata = {st_ff.ptr, 20'h0_0000};
        UER_OFS_FLAGS: nxt_st.rdata = st_ff.flags & UER_IMPL_BITS; // [RULE_20]
        UER_OFS_MASKS: nxt_st.rdata = st_ff.masks & UER_IMPL_BITS; // [RULE_20]
        default: nxt_st.rdata = UER_UNMAPPED_DATA;
      endcase
    end
    // Strap taken once after reset release, then the pointer is read-only
    if (~st_ff.strap_done) begin
      nxt_st.strap_done = 1'b1;
      nxt_st.ptr = port_downstream ? UER_PTR_DOWNSTREAM : UER_PTR_UPSTREAM; // [RULE_01] [RULE_02]
    end
    // Write one to clear; an event in the same cycle wins over the clear
    nxt_st.flags = st_ff.flags;
    if (commit_wr && word_adr == UER_OFS_FLAGS) begin
      nxt_st.flags = st_ff.flags & ~(wb_dat_i & sel_mask);
    end
    nxt_st.flags = (nxt_st.flags | evt_vec) & UER_IMPL_BITS; // [RULE_03] [RULE_20]
    if (commit_wr && word_adr == UER_OFS_MASKS) begin
      nxt_st.masks = ((st_ff.masks & ~sel_mask) | (wb_dat_i & sel_mask)) & UER_IMPL_BITS; // [RULE_20]
    end
    // Masked errors still set their status flags but are kept out of the report
    nxt_st.report = evt_vec & ~st_ff.masks & UER_IMPL_BITS; // [RULE_14] [RULE_15] [RULE_16]
    // Same gating covers the remaining mask bits // [RULE_17] [RULE_18] [RULE_19]
    // Non-power reset keeps the sticky flags, masks and pointer, clears ack, read data and report
    if (link_rst) begin
      nxt_st.ack = 1'b0;
      nxt_st.rdata = UER_UNMAPPED_DATA;
      nxt_st.report = 32'h0000_0000;
      nxt_st.flags = (st_ff.flags | evt_vec) & UER_IMPL_BITS; // [RULE_03]
      nxt_st.masks = st_ff.masks; // [RULE_14]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff.ack <= 1'b0;
      st_ff.rdata <= UER_UNMAPPED_DATA;
      st_ff.flags <= UER_FLAGS_RESET;
      st_ff.masks <= UER_MASKS_RESET;
      st_ff.ptr <= UER_PTR_UPSTREAM;
      st_ff.strap_done <= 1'b0;
      st_ff.report <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdata;
  assign fault_report = st_ff.report;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_new_req;
    req & ~st_ff.ack & ~link_rst;
  endsequence

  sequence s_ack_pulse;
    st_ff.ack ##1 ~st_ff.ack;
  endsequence

  chk_ptr_upstream: assert property ( // [RULE_01]
    st_ff.strap_done & ~$past(port_downstream) & $rose(st_ff.strap_done)
    |-> st_ff.ptr == UER_PTR_UPSTREAM)
    else $error("upstream pointer reset value wrong");

  chk_ptr_downstream: assert property ( // [RULE_02]
    $rose(st_ff.strap_done) & $past(port_downstream) |-> st_ff.ptr == UER_PTR_DOWNSTREAM)
    else $error("downstream pointer reset value wrong");

  chk_ptr_readonly: assert property ( // [RULE_01]
    st_ff.strap_done |=> $stable(st_ff.ptr))
    else $error("pointer changed after strap");

  chk_event_sets_flag: assert property ( // [RULE_03] [RULE_04] [RULE_05] [RULE_13]
    |evt_vec |=> ((st_ff.flags & $past(evt_vec)) == $past(evt_vec)))
    else $error("event did not set its status bit");

  chk_w1c_clear: assert property ( // [RULE_03] [RULE_12]
    commit_wr && word_adr == UER_OFS_FLAGS && ~link_rst
    |=> ((st_ff.flags & $past(wb_dat_i & sel_mask) & ~$past(evt_vec)) == 32'h0000_0000))
    else $error("write one did not clear status bit");

  chk_sticky_hold: assert property ( // [RULE_03]
    link_rst & ~|evt_vec |=> $stable(st_ff.flags) & $stable(st_ff.masks))
    else $error("sticky bits lost on non-power reset");

  chk_mask_gate: assert property ( // [RULE_14] [RULE_15] [RULE_16] [RULE_17]
    ##1 ~$past(link_rst) |-> fault_report == ($past(evt_vec) & ~$past(st_ff.masks) & UER_IMPL_BITS))
    else $error("report not gated by mask"); // [RULE_18] [RULE_19]

  chk_reserved_zero: assert property ( // [RULE_20]
    ((st_ff.flags | st_ff.masks) & ~UER_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved bit set");

  chk_ack_single: assert property (
    s_new_req |=> s_ack_pulse)
    else $error("ack not a single pulse after request");

  // Helper vectors for the per-bit checks
  logic flag_wr;
  logic [31:0] clr_vec;
  logic [31:0] open_vec;
  logic [31:0] hid_vec;
  assign flag_wr = commit_wr & (word_adr == UER_OFS_FLAGS) & ~link_rst;
  assign clr_vec = wb_dat_i & sel_mask & ~evt_vec & {32{flag_wr}};
  assign open_vec = evt_vec & ~st_ff.masks & {32{~link_rst}};
  assign hid_vec = evt_vec & st_ff.masks;

  // Each event field must land on its own status bit
  chk_set_training: assert property ( // [RULE_03]
    err_evt.training |=> st_ff.flags[UER_BIT_TRAINING])
    else $error("training error flag not set");

  chk_set_dl_proto: assert property ( // [RULE_04]
    err_evt.dl_proto |=> st_ff.flags[UER_BIT_DL_PROTO])
    else $error("link protocol flag not set");

  chk_set_poisoned: assert property ( // [RULE_05]
    err_evt.poisoned |=> st_ff.flags[UER_BIT_POISONED])
    else $error("poisoned flag not set");

  chk_set_fc_proto: assert property ( // [RULE_06]
    err_evt.fc_proto |=> st_ff.flags[UER_BIT_FC_PROTO])
    else $error("flow control flag not set");

  chk_set_cpl_timeout: assert property ( // [RULE_07]
    err_evt.cpl_timeout |=> st_ff.flags[UER_BIT_CPL_TIMEOUT])
    else $error("completion timeout flag not set");

  chk_set_cpl_abort: assert property ( // [RULE_08]
    err_evt.cpl_abort |=> st_ff.flags[UER_BIT_CPL_ABORT])
    else $error("completer abort flag not set");

  chk_set_unexp_cpl: assert property ( // [RULE_09]
    err_evt.unexp_cpl |=> st_ff.flags[UER_BIT_UNEXP_CPL])
    else $error("unexpected completion flag not set");

  chk_set_rx_overflow: assert property ( // [RULE_10]
    err_evt.rx_overflow |=> st_ff.flags[UER_BIT_RX_OVERFLOW])
    else $error("overflow flag not set");

  chk_set_malformed: assert property ( // [RULE_11]
    err_evt.malformed |=> st_ff.flags[UER_BIT_MALFORMED])
    else $error("malformed flag not set");

  chk_set_ecrc: assert property ( // [RULE_12]
    err_evt.ecrc |=> st_ff.flags[UER_BIT_ECRC])
    else $error("crc flag not set");

  chk_set_unsup_req: assert property ( // [RULE_13]
    err_evt.unsup_req |=> st_ff.flags[UER_BIT_UNSUP_REQ])
    else $error("unsupported request flag not set");

  // Write one clears, unless an event lands in the same cycle
  chk_clr_training: assert property ( // [RULE_03]
    clr_vec[UER_BIT_TRAINING] |=> ~st_ff.flags[UER_BIT_TRAINING])
    else $error("training error flag not cleared");

  chk_clr_dl_proto: assert property ( // [RULE_04]
    clr_vec[UER_BIT_DL_PROTO] |=> ~st_ff.flags[UER_BIT_DL_PROTO])
    else $error("link protocol flag not cleared");

  chk_clr_poisoned: assert property ( // [RULE_05]
    clr_vec[UER_BIT_POISONED] |=> ~st_ff.flags[UER_BIT_POISONED])
    else $error("poisoned flag not cleared");

  chk_clr_fc_proto: assert property ( // [RULE_06]
    clr_vec[UER_BIT_FC_PROTO] |=> ~st_ff.flags[UER_BIT_FC_PROTO])
    else $error("flow control flag not cleared");

  chk_clr_cpl_timeout: assert property ( // [RULE_07]
    clr_vec[UER_BIT_CPL_TIMEOUT] |=> ~st_ff.flags[UER_BIT_CPL_TIMEOUT])
    else $error("completion timeout flag not cleared");

  chk_clr_cpl_abort: assert property ( // [RULE_08]
    clr_vec[UER_BIT_CPL_ABORT] |=> ~st_ff.flags[UER_BIT_CPL_ABORT])
    else $error("completer abort flag not cleared");

  chk_clr_unexp_cpl: assert property ( // [RULE_09]
    clr_vec[UER_BIT_UNEXP_CPL] |=> ~st_ff.flags[UER_BIT_UNEXP_CPL])
    else $error("unexpected completion flag not cleared");

  chk_clr_rx_overflow: assert property ( // [RULE_10]
    clr_vec[UER_BIT_RX_OVERFLOW] |=> ~st_ff.flags[UER_BIT_RX_OVERFLOW])
    else $error("overflow flag not cleared");

  chk_clr_malformed: assert property ( // [RULE_11]
    clr_vec[UER_BIT_MALFORMED] |=> ~st_ff.flags[UER_BIT_MALFORMED])
    else $error("malformed flag not cleared");

  chk_clr_ecrc: assert property ( // [RULE_12]
    clr_vec[UER_BIT_ECRC] |=> ~st_ff.flags[UER_BIT_ECRC])
    else $error("crc flag not cleared");

  chk_clr_unsup_req: assert property ( // [RULE_13]
    clr_vec[UER_BIT_UNSUP_REQ] |=> ~st_ff.flags[UER_BIT_UNSUP_REQ])
    else $error("unsupported request flag not cleared");

  // An unmasked event must reach the report one cycle later
  chk_rep_training: assert property ( // [RULE_14]
    open_vec[UER_BIT_TRAINING] |=> fault_report[UER_BIT_TRAINING])
    else $error("training error not reported");

  chk_rep_dl_proto: assert property ( // [RULE_14]
    open_vec[UER_BIT_DL_PROTO] |=> fault_report[UER_BIT_DL_PROTO])
    else $error("link protocol error not reported");

  chk_rep_poisoned: assert property ( // [RULE_15]
    open_vec[UER_BIT_POISONED] |=> fault_report[UER_BIT_POISONED])
    else $error("poisoned packet not reported");

  chk_rep_fc_proto: assert property ( // [RULE_15]
    open_vec[UER_BIT_FC_PROTO] |=> fault_report[UER_BIT_FC_PROTO])
    else $error("flow control error not reported");

  chk_rep_cpl_timeout: assert property ( // [RULE_16]
    open_vec[UER_BIT_CPL_TIMEOUT] |=> fault_report[UER_BIT_CPL_TIMEOUT])
    else $error("completion timeout not reported");

  chk_rep_cpl_abort: assert property ( // [RULE_16]
    open_vec[UER_BIT_CPL_ABORT] |=> fault_report[UER_BIT_CPL_ABORT])
    else $error("completer abort not reported");

  chk_rep_unexp_cpl: assert property ( // [RULE_17]
    open_vec[UER_BIT_UNEXP_CPL] |=> fault_report[UER_BIT_UNEXP_CPL])
    else $error("unexpected completion not reported");

  chk_rep_rx_overflow: assert property ( // [RULE_17]
    open_vec[UER_BIT_RX_OVERFLOW] |=> fault_report[UER_BIT_RX_OVERFLOW])
    else $error("overflow not reported");

  chk_rep_malformed: assert property ( // [RULE_18]
    open_vec[UER_BIT_MALFORMED] |=> fault_report[UER_BIT_MALFORMED])
    else $error("malformed packet not reported");

  chk_rep_ecrc: assert property ( // [RULE_18]
    open_vec[UER_BIT_ECRC] |=> fault_report[UER_BIT_ECRC])
    else $error("crc error not reported");

  chk_rep_unsup_req: assert property ( // [RULE_19]
    open_vec[UER_BIT_UNSUP_REQ] |=> fault_report[UER_BIT_UNSUP_REQ])
    else $error("unsupported request not reported");

  // A masked event must stay out of the report
  chk_hide_training: assert property ( // [RULE_14]
    hid_vec[UER_BIT_TRAINING] |=> ~fault_report[UER_BIT_TRAINING])
    else $error("masked training error reported");

  chk_hide_dl_proto: assert property ( // [RULE_14]
    hid_vec[UER_BIT_DL_PROTO] |=> ~fault_report[UER_BIT_DL_PROTO])
    else $error("masked link protocol error reported");

  chk_hide_poisoned: assert property ( // [RULE_15]
    hid_vec[UER_BIT_POISONED] |=> ~fault_report[UER_BIT_POISONED])
    else $error("masked poisoned packet reported");

  chk_hide_fc_proto: assert property ( // [RULE_15]
    hid_vec[UER_BIT_FC_PROTO] |=> ~fault_report[UER_BIT_FC_PROTO])
    else $error("masked flow control error reported");

  chk_hide_cpl_timeout: assert property ( // [RULE_16]
    hid_vec[UER_BIT_CPL_TIMEOUT] |=> ~fault_report[UER_BIT_CPL_TIMEOUT])
    else $error("masked completion timeout reported");

  chk_hide_cpl_abort: assert property ( // [RULE_16]
    hid_vec[UER_BIT_CPL_ABORT] |=> ~fault_report[UER_BIT_CPL_ABORT])
    else $error("masked completer abort reported");

  chk_hide_unexp_cpl: assert property ( // [RULE_17]
    hid_vec[UER_BIT_UNEXP_CPL] |=> ~fault_report[UER_BIT_UNEXP_CPL])
    else $error("masked unexpected completion reported");

  chk_hide_rx_overflow: assert property ( // [RULE_17]
    hid_vec[UER_BIT_RX_OVERFLOW] |=> ~fault_report[UER_BIT_RX_OVERFLOW])
    else $error("masked overflow reported");

  chk_hide_malformed: assert property ( // [RULE_18]
    hid_vec[UER_BIT_MALFORMED] |=> ~fault_report[UER_BIT_MALFORMED])
    else $error("masked malformed packet reported");

  chk_hide_ecrc: assert property ( // [RULE_18]
    hid_vec[UER_BIT_ECRC] |=> ~fault_report[UER_BIT_ECRC])
    else $error("masked crc error reported");

  chk_hide_unsup_req: assert property ( // [RULE_19]
    hid_vec[UER_BIT_UNSUP_REQ] |=> ~fault_report[UER_BIT_UNSUP_REQ])
    else $error("masked unsupported request reported");

  // Bus and reserved-bit housekeeping
  chk_report_reserved: assert property ( // [RULE_20]
    (fault_report & ~UER_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved report bit set");

  chk_rdata_hold: assert property (
    ~(req & ~st_ff.ack) & ~link_rst |=> $stable(wb_dat_o))
    else $error("read data changed without request");

  chk_link_quiet: assert property (
    link_rst |=> ~wb_ack_o & (fault_report == 32'h0000_0000))
    else $error("non-power reset left ack or report set");

endmodule : uer_regs

// ---- uer_regs_tb.sv ----
// Self-checking testbench for the uncorrectable-error register bank
`timescale 1ns/1ps

module uer_regs_tb;
  import uer_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_rst = 1'b0;
  logic port_downstream = 1'b0;
  uer_evt_s err_evt = '0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [31:0] fault_report;
  logic [31:0] rd;
  int miscompares = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  uer_regs DUT (.clk(clk), .rst(rst), .link_rst(link_rst), .port_downstream(port_downstream),
    .err_evt(err_evt), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fault_report(fault_report));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until ack is seen, then releases at the following edge
  task xfer(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : xfer

  task rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  // One-cycle event pulse; report is due the cycle after and gone the next
  task evt(input uer_evt_s v, input logic [31:0] exp_rep);
    @(posedge clk);
    err_evt <= v;
    @(posedge clk);
    err_evt <= '0;
    #1;
    chk(fault_report, exp_rep);
    @(posedge clk);
    #1;
    chk(fault_report, 32'h0000_0000);
  endtask : evt

  task do_reset(input logic ds);
    rst <= 1'b1;
    port_downstream <= ds;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task t_reset_vals;
    rd_chk(UER_OFS_NEXT_CAP, {UER_PTR_UPSTREAM, 20'h0_0000});
    xfer(1'b1, UER_OFS_NEXT_CAP, 32'hFFFF_FFFF);
    rd_chk(UER_OFS_NEXT_CAP, {UER_PTR_UPSTREAM, 20'h0_0000});
    rd_chk(UER_OFS_FLAGS, 32'h0000_0000);
    rd_chk(UER_OFS_MASKS, 32'h0000_0000);
    rd_chk(12'h10C, 32'h0000_0000);
    $display("test reset_vals done");
  endtask : t_reset_vals

  task t_events;
    int pos;
    for (int i = 0; i < 11; i++) begin
      pos = (i == 10) ? 0 : (i == 9) ? 4 : 20 - i;
      evt(uer_evt_s'(11'h001 << i), 32'h1 << pos);
      rd_chk(UER_OFS_FLAGS, 32'h1 << pos);
      xfer(1'b1, UER_OFS_FLAGS, 32'h1 << pos);
      rd_chk(UER_OFS_FLAGS, 32'h0000_0000);
    end
    $display("test events done");
  endtask : t_events

  task t_masks;
    xfer(1'b1, UER_OFS_MASKS, 32'h0015_5010);
    evt(uer_evt_s'(11'h7FF), 32'h000A_A001);
    xfer(1'b1, UER_OFS_FLAGS, 32'hFFFF_FFFF);
    xfer(1'b1, UER_OFS_MASKS, 32'hFFFF_FFFF);
    rd_chk(UER_OFS_MASKS, UER_IMPL_BITS);
    evt(uer_evt_s'(11'h7FF), 32'h0000_0000);
    rd_chk(UER_OFS_FLAGS, UER_IMPL_BITS);
    @(posedge clk);
    link_rst <= 1'b1;
    @(posedge clk);
    link_rst <= 1'b0;
    rd_chk(UER_OFS_FLAGS, UER_IMPL_BITS);
    rd_chk(UER_OFS_MASKS, UER_IMPL_BITS);
    xfer(1'b1, UER_OFS_FLAGS, 32'hFFFF_FFFF);
    rd_chk(UER_OFS_FLAGS, 32'h0000_0000);
    $display("test masks done");
  endtask : t_masks

  task t_downstream;
    do_reset(1'b1);
    rd_chk(UER_OFS_NEXT_CAP, {UER_PTR_DOWNSTREAM, 20'h0_0000});
    rd_chk(UER_OFS_MASKS, 32'h0000_0000);
    $display("test downstream done");
  endtask : t_downstream

  task end_of_test;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  initial begin
    do_reset(1'b0);
    t_reset_vals();
    t_events();
    t_masks();
    t_downstream();
    end_of_test();
  end

  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule : uer_regs_tb
